// *** hdl/mcsync_pkg.sv ***
/*
 * Constants for the multi-chip sync and input controller: register map,
 * control bit positions, reset values and stretch lengths.
 * Assumes a single 250 MHz clock and an AXI4-Lite register bus.
 */
package mcsync_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] MCS_CTRL0_ADDR = 8'h00;
    localparam logic [7:0] MCS_CTRL7_ADDR = 8'h1C;
    localparam logic [7:0] MCS_CTRL8_ADDR = 8'h20;
    localparam logic [7:0] MCS_CTRL11_ADDR = 8'h2C;
    localparam logic [7:0] MCS_CTRL25_ADDR = 8'h64;
    localparam logic [7:0] MCS_SYNC_CMD_ADDR = 8'h80;
    localparam logic [7:0] MCS_STATUS_ADDR = 8'h84;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MCS_C0_OFFSET_BIN = 0;
    localparam int MCS_C0_INTERP = 2;
    localparam int MCS_C0_SYNC_BACK = 3;
    localparam int MCS_C0_NCO_SYNC_EN = 19;
    localparam int MCS_C0_CIC_SYNC_EN = 20;
    localparam int MCS_C7_FILT_SYNC_EN = 21;
    localparam int MCS_C8_AGC_SYNC_EN = 29;
    localparam int MCS_C11_TNCO_LOAD = 5;
    localparam int MCS_CMD_SYNC = 0;
    localparam int MCS_CMD_MASTER = 1;
    localparam int MCS_ST_FRONT_RST = 0;
    localparam int MCS_ST_BACK_RST = 1;
    localparam int MCS_ST_BUF_FULL = 2;
    localparam int MCS_ST_FRONT_CNT = 8;
    localparam int MCS_ST_BACK_CNT = 16;

    // ------------------------------------------------------------
    // Reset values and responses
    // ------------------------------------------------------------
    localparam logic [31:0] MCS_CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] MCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] MCS_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MCS_CLK_PERIOD_NS = 4;
    localparam int MCS_SOFT_RESET_PERIODS = 10;
    localparam logic [3:0] MCS_SOFT_RESET_CYCLES = 4'(MCS_SOFT_RESET_PERIODS);

    localparam int MCS_SAMPLE_W = 14;

endpackage

// *** hdl/mcsync_buf2.sv ***
/*
 * Two-entry buffer with valid/ready on both sides and a flush.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module mcsync_buf2 import mcsync_pkg::*; #(
    parameter int WIDTH = MCS_SAMPLE_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic flush_in,
    // Filling side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // Draining side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic full_out
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic wr;
        logic rd;
        logic [1:0] cnt;
    } mcs_buf_s;

    mcs_buf_s st_r;
    mcs_buf_s st_nxt;
    logic push;
    logic pop;

    assign in_ready_out = (st_r.cnt != 2'h2);
    assign out_valid_out = (st_r.cnt != 2'h0);
    assign out_data_out = st_r.mem[st_r.rd];
    assign full_out = (st_r.cnt == 2'h2);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = in_data_in;
            st_nxt.wr = ~st_r.wr;
        end
        if (pop) begin
            st_nxt.rd = ~st_r.rd;
        end
        st_nxt.cnt = 2'(st_r.cnt + {1'b0, push} - {1'b0, pop});
        if (flush_in) begin
            st_nxt.wr = 1'b0;
            st_nxt.rd = 1'b0;
            st_nxt.cnt = 2'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

`default_nettype wire

// *** hdl/mcsync_ctrl.sv ***
/*
 * Multi-chip sync routing, stretched software reset and input sample
 * controller, with an AXI4-Lite register slave.
 * Assumes one clock for the front and back halves, synchronous inputs,
 * and that the board wires the sync lines between parts.
 */
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module mcsync_ctrl import mcsync_pkg::*; (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Sync lines
    input wire logic front_sync_in,
    input wire logic back_sync_in,
    input wire logic master_sync_in,
    output logic sync_pulse_out,
    output logic master_sync_out,
    // Front-end stage controls
    output logic front_soft_reset_out,
    output logic nco_update_out,
    output logic nco_feedback_clear_out,
    output logic cic_count_reset_out,
    // Back-end stage controls
    output logic back_soft_reset_out,
    output logic agc_load_out,
    output logic timing_nco_load_out,
    output logic timing_nco_reset_out,
    output logic filter_reset_out,
    output logic resampler_reset_out,
    output logic resampler_nco_update_out,
    // Input samples
    input wire logic [MCS_SAMPLE_W-1:0] sample_in,
    input wire logic input_sample_enable_in,
    output logic sample_ready_out,
    output logic [MCS_SAMPLE_W-1:0] sample_out,
    output logic sample_valid_out,
    input wire logic sample_ready_in
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl0;
        logic [31:0] ctrl7;
        logic [31:0] ctrl8;
        logic [31:0] ctrl11;
        logic [3:0] front_rst_cnt;
        logic [3:0] back_rst_cnt;
        logic front_q;
        logic front_q2;
        logic back_q;
        logic back_q2;
        logic master_q;
        logic master_q2;
        logic sync_trig;
        logic sync_back_stage;
        logic sync_out;
        logic msync_out;
        logic nco_update;
        logic cic_reset;
        logic agc_load;
        logic tnco_load;
        logic tnco_reset;
        logic filt_reset;
        logic resamp_reset;
        logic [7:0] front_cnt;
        logic [7:0] back_cnt;
    } mcs_state_s;

    mcs_state_s st_r;
    mcs_state_s st_nxt;

    logic buf_full;
    logic buf_in_ready;
    logic smp_valid;
    logic [MCS_SAMPLE_W-1:0] smp_data;
    logic front_rst_act;
    logic back_rst_act;
    logic front_edge;
    logic back_edge;
    logic master_edge;
    logic do_write;
    logic sync_cmd_wr;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == MCS_CTRL0_ADDR) || (a == MCS_CTRL7_ADDR) ||
               (a == MCS_CTRL8_ADDR) || (a == MCS_CTRL11_ADDR) ||
               (a == MCS_CTRL25_ADDR) || (a == MCS_SYNC_CMD_ADDR) ||
               (a == MCS_STATUS_ADDR);
    endfunction

    function automatic logic [3:0] count_down(input logic [3:0] c);
        return (c != 4'h0) ? 4'(c - 4'h1) : 4'h0;
    endfunction

    // ------------------------------------------------------------
    // Decoded conditions
    // ------------------------------------------------------------
    assign front_rst_act = (st_r.front_rst_cnt != 4'h0);
    assign back_rst_act = (st_r.back_rst_cnt != 4'h0);
    // Edges are taken from registered copies, each in its own half.
    assign front_edge = st_r.front_q && !st_r.front_q2 && !front_rst_act;
    assign back_edge = st_r.back_q && !st_r.back_q2 && !back_rst_act;
    assign master_edge = st_r.master_q && !st_r.master_q2;
    assign do_write = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign sync_cmd_wr = do_write && (st_r.aw_addr == MCS_SYNC_CMD_ADDR) && st_r.w_strb[0];

    // ------------------------------------------------------------
    // Input sample path
    // ------------------------------------------------------------
    always_comb begin
        smp_data = sample_in;
        if (st_r.ctrl0[MCS_C0_OFFSET_BIN]) begin
            smp_data[MCS_SAMPLE_W-1] = ~sample_in[MCS_SAMPLE_W-1];
        end
        if (st_r.ctrl0[MCS_C0_INTERP]) begin
            smp_valid = !front_rst_act;
            if (!input_sample_enable_in) begin
                smp_data = '0;
            end
        end else begin
            smp_valid = input_sample_enable_in && !front_rst_act;
        end
    end

    assign sample_ready_out = buf_in_ready && !front_rst_act;

    mcsync_buf2 #(
        .WIDTH(MCS_SAMPLE_W)
    ) u_buf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .flush_in(front_rst_act),
        .in_data_in(smp_data),
        .in_valid_in(smp_valid),
        .in_ready_out(buf_in_ready),
        .out_data_out(sample_out),
        .out_valid_out(sample_valid_out),
        .out_ready_in(sample_ready_in),
        .full_out(buf_full)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // Write address and data are taken in either order.
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            st_nxt.w_got = 1'b1;
            st_nxt.w_data = s_axi_wdata_in;
            st_nxt.w_strb = s_axi_wstrb_in;
        end
        if (do_write) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = addr_mapped(st_r.aw_addr) ? MCS_RESP_OKAY : MCS_RESP_SLVERR;
            unique case (st_r.aw_addr)
                MCS_CTRL0_ADDR: begin
                    st_nxt.ctrl0 = merge_bytes(st_r.ctrl0, st_r.w_data, st_r.w_strb);
                end
                MCS_CTRL7_ADDR: begin
                    st_nxt.ctrl7 = merge_bytes(st_r.ctrl7, st_r.w_data, st_r.w_strb);
                end
                MCS_CTRL8_ADDR: begin
                    st_nxt.ctrl8 = merge_bytes(st_r.ctrl8, st_r.w_data, st_r.w_strb);
                end
                MCS_CTRL11_ADDR: begin
                    st_nxt.ctrl11 = merge_bytes(st_r.ctrl11, st_r.w_data, st_r.w_strb);
                end
                default: begin
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready_in) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read: one word answered the cycle after the address is taken.
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = addr_mapped(s_axi_araddr_in) ? MCS_RESP_OKAY : MCS_RESP_SLVERR;
            unique case (s_axi_araddr_in)
                MCS_CTRL0_ADDR: st_nxt.rdata = st_r.ctrl0;
                MCS_CTRL7_ADDR: st_nxt.rdata = st_r.ctrl7;
                MCS_CTRL8_ADDR: st_nxt.rdata = st_r.ctrl8;
                MCS_CTRL11_ADDR: st_nxt.rdata = st_r.ctrl11;
                MCS_STATUS_ADDR: begin
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.rdata[MCS_ST_FRONT_RST] = front_rst_act;
                    st_nxt.rdata[MCS_ST_BACK_RST] = back_rst_act;
                    st_nxt.rdata[MCS_ST_BUF_FULL] = buf_full;
                    st_nxt.rdata[MCS_ST_FRONT_CNT +: 8] = st_r.front_cnt;
                    st_nxt.rdata[MCS_ST_BACK_CNT +: 8] = st_r.back_cnt;
                end
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end else if (st_r.rvalid && s_axi_rready_in) begin
            st_nxt.rvalid = 1'b0;
        end

        // Software reset is stretched separately in each half.
        st_nxt.front_rst_cnt = count_down(st_r.front_rst_cnt);
        st_nxt.back_rst_cnt = count_down(st_r.back_rst_cnt);
        if (do_write && (st_r.aw_addr == MCS_CTRL25_ADDR)) begin
            st_nxt.front_rst_cnt = MCS_SOFT_RESET_CYCLES;
            st_nxt.back_rst_cnt = MCS_SOFT_RESET_CYCLES;
        end

        // Sync line capture.
        st_nxt.front_q = front_sync_in;
        st_nxt.front_q2 = st_r.front_q;
        st_nxt.back_q = back_sync_in;
        st_nxt.back_q2 = st_r.back_q;
        st_nxt.master_q = master_sync_in;
        st_nxt.master_q2 = st_r.master_q;

        // Outgoing sync: a command or a master edge, timed to one half.
        st_nxt.sync_trig = (sync_cmd_wr && st_r.w_data[MCS_CMD_SYNC]) || master_edge;
        st_nxt.msync_out = sync_cmd_wr && st_r.w_data[MCS_CMD_MASTER];
        st_nxt.sync_back_stage = st_r.sync_trig && st_r.ctrl0[MCS_C0_SYNC_BACK] && !back_rst_act;
        if (st_r.ctrl0[MCS_C0_SYNC_BACK]) begin
            st_nxt.sync_out = st_r.sync_back_stage;
        end else begin
            st_nxt.sync_out = st_r.sync_trig && !front_rst_act;
        end

        // Front-end half actions.
        st_nxt.nco_update = front_edge && st_r.ctrl0[MCS_C0_NCO_SYNC_EN];
        st_nxt.cic_reset = front_edge && st_r.ctrl0[MCS_C0_CIC_SYNC_EN];
        if (front_edge) begin
            st_nxt.front_cnt = 8'(st_r.front_cnt + 8'h01);
        end

        // Back-end half actions.
        st_nxt.agc_load = back_edge && st_r.ctrl8[MCS_C8_AGC_SYNC_EN];
        st_nxt.tnco_load = back_edge && st_r.ctrl11[MCS_C11_TNCO_LOAD];
        st_nxt.tnco_reset = back_edge && !st_r.ctrl11[MCS_C11_TNCO_LOAD];
        st_nxt.filt_reset = back_edge && st_r.ctrl7[MCS_C7_FILT_SYNC_EN];
        st_nxt.resamp_reset = back_edge;
        if (back_edge) begin
            st_nxt.back_cnt = 8'(st_r.back_cnt + 8'h01);
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Front and back halves share the one clock, each on its rising edge.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= '0;
            st_r.ctrl0 <= MCS_CTRL_RESET;
            st_r.ctrl7 <= MCS_CTRL_RESET;
            st_r.ctrl8 <= MCS_CTRL_RESET;
            st_r.ctrl11 <= MCS_CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready_out = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready_out = !st_r.w_got && !st_r.bvalid;
    assign s_axi_bvalid_out = st_r.bvalid;
    assign s_axi_bresp_out = st_r.bresp;
    assign s_axi_arready_out = !st_r.rvalid;
    assign s_axi_rvalid_out = st_r.rvalid;
    assign s_axi_rdata_out = st_r.rdata;
    assign s_axi_rresp_out = st_r.rresp;

    assign sync_pulse_out = st_r.sync_out;
    assign master_sync_out = st_r.msync_out;
    assign front_soft_reset_out = front_rst_act;
    assign back_soft_reset_out = back_rst_act;
    assign nco_update_out = st_r.nco_update;
    assign nco_feedback_clear_out = st_r.nco_update;
    assign cic_count_reset_out = st_r.cic_reset;
    assign agc_load_out = st_r.agc_load;
    assign timing_nco_load_out = st_r.tnco_load;
    assign timing_nco_reset_out = st_r.tnco_reset;
    assign filter_reset_out = st_r.filt_reset;
    assign resampler_reset_out = st_r.resamp_reset;
    assign resampler_nco_update_out = st_r.resamp_reset;

endmodule

`default_nettype wire

// *** tb/mcsync_ctrl_props.sv ***
/* Concurrent checks on the sync controller ports.
   Assumes the bind below and a single clock domain. */
`timescale 1ns/10ps
`default_nettype none
module mcsync_ctrl_props import mcsync_pkg::*; (
    // Observed ports
    input wire logic clk_in, rst_in, front_sync_in, back_sync_in,
    input wire logic s_axi_bvalid_out, s_axi_bready_in, s_axi_rvalid_out,
    input wire logic s_axi_rready_in, master_sync_out, sample_ready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic front_soft_reset_out, back_soft_reset_out, nco_update_out,
    input wire logic nco_feedback_clear_out, cic_count_reset_out, agc_load_out,
    input wire logic filter_reset_out, timing_nco_load_out, timing_nco_reset_out,
    input wire logic resampler_reset_out, resampler_nco_update_out,
    input wire logic sample_valid_out, sample_ready_in,
    input wire logic [MCS_SAMPLE_W-1:0] sample_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ----
    // Rising sync edge seen two cycles back
    // ----
    sequence s_front;
        $past(front_sync_in, 2) && !$past(front_sync_in, 3);
    endsequence
    sequence s_back;
        $past(back_sync_in, 2) && !$past(back_sync_in, 3);
    endsequence
    AST_NCO: assert property (nco_update_out |->
        nco_feedback_clear_out ##0 s_front) else $error("stray nco pulse");
    AST_CIC: assert property (cic_count_reset_out |-> s_front)
        else $error("stray comb reset");
    AST_AGC: assert property (agc_load_out |-> s_back)
        else $error("stray gain load");
    AST_BACK: assert property (filter_reset_out || timing_nco_load_out ||
        timing_nco_reset_out |-> s_back) else $error("stray back pulse");
    AST_TNCO: assert property (!(timing_nco_load_out && timing_nco_reset_out))
        else $error("load with reset");
    AST_RSMP: assert property ($rose(back_sync_in) && !back_soft_reset_out |->
        ##2 resampler_reset_out && resampler_nco_update_out) else $error("no resampler reset");
    AST_SRST: assert property ($rose(front_soft_reset_out) |->
        (front_soft_reset_out && back_soft_reset_out)[*8] ##1
        (front_soft_reset_out && back_soft_reset_out)[*2] ##1 !front_soft_reset_out)
        else $error("soft reset width");
    AST_SRDY: assert property (front_soft_reset_out |-> !sample_ready_out)
        else $error("samples taken in reset");
    AST_SHOLD: assert property (!front_soft_reset_out && sample_valid_out && !sample_ready_in |=>
        sample_valid_out && $stable(sample_out)) else $error("sample dropped");
    AST_BHOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("bresp dropped");
    AST_RHOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("rdata dropped");
    AST_MSO: assert property (master_sync_out |=> !master_sync_out)
        else $error("master pulse too long");
endmodule
bind mcsync_ctrl mcsync_ctrl_props u_props (.*);
`default_nettype wire

// *** tb/mcsync_peer.sv ***
/* Other parts on the shared sync lines.
   Assumes the bench calls pulse and feeds back the master sync. */
`timescale 1ns/10ps
`default_nettype none
module mcsync_peer (
    // Clock and options
    input wire logic clk_in,
    input wire logic join_in,
    input wire logic msync_in,
    // Sync lines
    output logic front_out,
    output logic back_out,
    output logic master_out
);
    logic front_r = 1'h0;
    logic back_r = 1'h0;
    logic msync_r = 1'h0;
    assign front_out = front_r;
    // Both inputs joined when the two halves share one clock source.
    assign back_out = join_in ? front_r : back_r;
    assign master_out = msync_r;
    always @(posedge clk_in) msync_r <= msync_in;
    task automatic pulse(input logic bk, input int n);
        @(posedge clk_in);
        if (bk) back_r <= 1'h1;
        else front_r <= 1'h1;
        repeat (n) @(posedge clk_in);
        back_r <= 1'h0;
        front_r <= 1'h0;
    endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/* Bench for the sync controller: AXI4-Lite tasks, peer sync lines,
   sample stream checks. Assumes the package and a 250 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module tb_top import mcsync_pkg::*; ;
    localparam logic [1:0] OK = MCS_RESP_OKAY;
    logic clk_in = 1'h0, rst_in = 1'h1, join_r = 1'h0;
    logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
    logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
    logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, d;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, ok, front_sync_in, back_sync_in, master_sync_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
    logic sync_pulse_out, master_sync_out, front_soft_reset_out, nco_update_out;
    logic nco_feedback_clear_out, cic_count_reset_out, back_soft_reset_out;
    logic agc_load_out, timing_nco_load_out, timing_nco_reset_out, filter_reset_out;
    logic resampler_reset_out, resampler_nco_update_out, sample_ready_out;
    logic [MCS_SAMPLE_W-1:0] sample_in = 14'h0, sample_out, got [$];
    logic input_sample_enable_in = 1'h0, sample_ready_in = 1'h1, sample_valid_out;
    logic [8:0] pv;
    int cnt [9], srcnt, failures, n_compared, k, acc, nz, lat [2];
    mcsync_ctrl u_dut (.*);
    mcsync_peer u_peer (.clk_in(clk_in), .join_in(join_r), .msync_in(master_sync_out),
        .front_out(front_sync_in), .back_out(back_sync_in), .master_out(master_sync_in));
    assign pv = {nco_update_out, cic_count_reset_out, agc_load_out, timing_nco_load_out,
        timing_nco_reset_out, filter_reset_out, resampler_reset_out, sync_pulse_out,
        master_sync_out};
    initial forever #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        for (int i = 0; i < 9; i++) cnt[i] += pv[i];
        srcnt += front_soft_reset_out + back_soft_reset_out;
        if (sample_valid_out && sample_ready_in) got.push_back(sample_out);
    end
    // ----
    // Shared tasks
    // ----
    task automatic finish_test;
        $display("failures=%0d n_compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 20) begin
            failures++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= v;
        s_axi_awvalid_in <= 1'h1;
        s_axi_wvalid_in <= 1'h1;
        s_axi_bready_in <= 1'h1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
            if (s_axi_bvalid_out) break;
        end
        hang(n);
        s_axi_bready_in <= 1'h0;
        chk(s_axi_bresp_out, er);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'h1;
        s_axi_rready_in <= 1'h1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
            if (s_axi_rvalid_out) break;
        end
        hang(n);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'h0;
    endtask
    task automatic pc(input logic [8:0] e);
        for (int i = 0; i < 9; i++) chk(cnt[i], e[i]);
        cnt = '{default: 0};
    endtask
    task automatic send(input logic [MCS_SAMPLE_W-1:0] v);
        int n;
        @(posedge clk_in);
        sample_in <= v;
        input_sample_enable_in <= 1'h1;
        for (n = 0; n < 8; n++) begin
            @(posedge clk_in);
            if (sample_ready_out) break;
        end
        ok = n < 8;
        input_sample_enable_in <= 1'h0;
        sample_in <= ~v;
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'h0;
        rd(MCS_CTRL0_ADDR);
        chk(d, MCS_CTRL_RESET);
        rd(MCS_STATUS_ADDR);
        chk(d, 32'h0);
        rd(8'h40);
        chk(r, MCS_RESP_SLVERR);
        wr(8'h44, 32'h1, MCS_RESP_SLVERR);
        cnt = '{default: 0};
        for (int i = 0; i < 4; i++) begin
            wr(MCS_CTRL0_ADDR, 32'(i) << 19, OK);
            u_peer.pulse(1'h0, 2);
            repeat (6) @(posedge clk_in);
            pc({i[0], i[1], 7'h0});
        end
        for (int i = 0; i < 8; i++) begin
            wr(MCS_CTRL8_ADDR, 32'(i & 1) << 29, OK);
            wr(MCS_CTRL7_ADDR, 32'(i >> 1 & 1) << 21, OK);
            wr(MCS_CTRL11_ADDR, 32'(i >> 2) << 5, OK);
            u_peer.pulse(1'h1, 2);
            repeat (6) @(posedge clk_in);
            pc({2'h0, i[0], i[2], !i[2], i[1], 3'h4});
        end
        rd(MCS_STATUS_ADDR);
        chk(d[23:8], 16'h0804);
        join_r <= 1'h1;
        u_peer.pulse(1'h0, 2);
        repeat (6) @(posedge clk_in);
        pc(9'h1EC);
        for (int m = 0; m < 2; m++) begin
            wr(MCS_CTRL0_ADDR, 32'(m) << 3, OK);
            wr(MCS_SYNC_CMD_ADDR, 32'h1, OK);
            for (k = 0; k < 10 && !sync_pulse_out; k++) @(posedge clk_in);
            lat[m] = k;
        end
        chk(lat[1], lat[0] + 1);
        repeat (4) @(posedge clk_in);
        cnt = '{default: 0};
        wr(MCS_SYNC_CMD_ADDR, 32'h2, OK);
        repeat (10) @(posedge clk_in);
        pc(9'h003);
        srcnt = 0;
        wr(MCS_CTRL25_ADDR, 32'h1, OK);
        u_peer.pulse(1'h0, 2);
        repeat (14) @(posedge clk_in);
        chk(srcnt, 2 * MCS_SOFT_RESET_PERIODS);
        pc(9'h0);
        join_r <= 1'h0;
        wr(MCS_CTRL0_ADDR, 32'h0, OK);
        got.delete();
        send(14'h1234);
        send(14'h2000);
        wr(MCS_CTRL0_ADDR, 32'h1, OK);
        send(14'h2000);
        send(14'h1FFF);
        repeat (4) @(posedge clk_in);
        chk(got.size(), 4);
        foreach (got[i]) chk(got[i], 14'({14'h3FFF, 14'h0000, 14'h2000, 14'h1234} >> 14*i));
        wr(MCS_CTRL0_ADDR, 32'h4, OK);
        repeat (3) @(posedge clk_in);
        got.delete();
        send(14'h0ABC);
        repeat (4) @(posedge clk_in);
        wr(MCS_CTRL0_ADDR, 32'h0, OK);
        repeat (4) @(posedge clk_in);
        nz = 0;
        foreach (got[i]) if (got[i] !== 14'h0) nz++;
        chk(nz, 1);
        chk(got.size() > 6, 1);
        got.delete();
        sample_ready_in <= 1'h0;
        acc = 0;
        for (int i = 0; i < 5; i++) begin
            send(14'h0100 + 14'(acc));
            acc += ok;
        end
        chk(sample_ready_out, 1'h0);
        rd(MCS_STATUS_ADDR);
        chk(d[MCS_ST_BUF_FULL], 1'h1);
        sample_ready_in <= 1'h1;
        repeat (6) @(posedge clk_in);
        chk(got.size(), acc);
        foreach (got[i]) chk(got[i], 14'h0100 + 14'(i));
        finish_test();
    end
endmodule
`default_nettype wire
